// ### src/adc_seq_pkg.sv
package adc_seq_pkg;
	// Avalon word addresses
	localparam logic [3:0] OFF_CONTROL_A   = 4'h0;
	localparam logic [3:0] OFF_CONTROL_B   = 4'h1;
	localparam logic [3:0] OFF_CONTROL_C   = 4'h2;
	localparam logic [3:0] OFF_CONTROL_D   = 4'h3;
	localparam logic [3:0] OFF_SAMPLE_CTRL = 4'h4;
	localparam logic [3:0] OFF_CHANNEL     = 4'h5;
	localparam logic [3:0] OFF_COMMAND     = 4'h6;
	localparam logic [3:0] OFF_EVENT_CTRL  = 4'h7;
	localparam logic [3:0] OFF_INT_ENABLE  = 4'h8;
	localparam logic [3:0] OFF_INT_FLAG    = 4'h9;
	localparam logic [3:0] OFF_RESULT      = 4'ha;

	// Field positions
	localparam int ENABLE_BIT = 0;
	localparam int CONT_BIT   = 1;
	localparam int RESLOW_BIT = 2;
	localparam int REF_LSB    = 4;

	// Reset values
	localparam logic [2:0] CTRL_A_RST = 3'h0;
	localparam logic [2:0] ACC_RST    = 3'h0;
	localparam logic [2:0] DIV_RST    = 3'h0;
	localparam logic [1:0] REF_RST    = 2'h0;
	localparam logic [3:0] DLY_RST    = 4'h0;
	localparam logic [4:0] LEN_RST    = 5'h00;
	localparam logic [4:0] CH_RST     = 5'h00;

	// Timing in converter clock cycles, and log2 of the largest sample count
	localparam logic [5:0] CONV_CYCLES = 6'h0d;
	localparam logic [5:0] SH_CYCLES   = 6'h02;
	localparam logic [2:0] ACC_MAX_LOG = 3'h6;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_RUN  = 2'b10
	} state_t;
endpackage : adc_seq_pkg

// ### src/conv_clk_if.sv
`timescale 1ns/1ps
interface conv_clk_if;
	logic       run;
	logic [2:0] div_sel;
	logic       tick;
	modport ctl (output run, output div_sel, input tick);
	modport clock_divider_select (input run, input div_sel, output tick);
endinterface : conv_clk_if

// ### src/adc_prescaler.sv
`timescale 1ns/1ps
module adc_prescaler
	import adc_seq_pkg::*;
(
	input wire logic   clk,
	input wire logic   rst_n,
	conv_clk_if.clock_divider_select  bus
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	wire  [7:0] half_w = 8'h01 << bus.div_sel;
	wire  [7:0] top_w  = (half_w << 1) - 8'h01;

	// Rising edge of the converter clock, mid period
	assign bus.tick = bus.run && (cnt_q == half_w - 8'h01); // RL10
	assign cnt_d    = !bus.run ? 8'h00 : (cnt_q == top_w) ? 8'h00 : cnt_q + 8'h01; // RL11 RL13

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	property p_clock_divider_select_hold;
		@(posedge clk) disable iff (!rst_n)
		!bus.run |=> cnt_q == 8'h00;
	endproperty
	a_clock_divider_select_hold: assert property (p_clock_divider_select_hold) else $error("prescaler not held"); // RL13
endmodule : adc_prescaler

// ### src/adc_accumulator.sv
`timescale 1ns/1ps
module adc_accumulator (
	input wire logic         clk,
	input wire logic         rst_n,
	input wire logic         load,
	input wire logic         add,
	input wire logic  [9:0]  sample,
	output logic      [15:0] sum
);
	logic [15:0] sum_q;
	wire  [15:0] ext_w = {6'h00, sample};

	assign sum = sum_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sum_q <= 16'h0000;
		end else if (load) begin
			sum_q <= ext_w; // RL24
		end else if (add) begin
			sum_q <= sum_q + ext_w; // RL23
		end
	end

	property p_load;
		@(posedge clk) disable iff (!rst_n)
		load |=> sum_q == {6'h00, $past(sample)};
	endproperty
	a_load: assert property (p_load) else $error("burst did not restart sum"); // RL24
endmodule : adc_accumulator

// ### src/adc_conversion_sequencer.sv
// How it works
// RL1 - Writing one to the start bit begins a conversion of the selected input.
// RL2 - Start bit reads one while converting; single mode clears it at completion.
// RL3 - A channel change during a conversion waits until that conversion ends.
// RL4 - A finished single or accumulated operation stores the result and sets ready flag.
// RL5 - Interrupt is requested only when its enable and the global enable are one.
// RL6 - Ready flag is set on completion even with its interrupt disabled.
// RL7 - With event start enabled, an incoming event triggers a conversion.
// RL8 - Events are edge detected, set the start bit; completion clears it.
// RL9 - Free-running: first start by write, next ones follow completion while bit stays.
// RL10 - Converter clock comes from the system clock through a selectable prescaler.
// RL11 - Prescaler counts while enabled and is held at zero when disabled; here it counts only while enabled and not idle.
// RL12 - After any trigger, conversion starts at the next converter clock rising edge.
// RL13 - Prescaler is held reset when idle, giving half factor plus two delay.
// RL14 - A plain conversion lasts thirteen converter clock cycles.
// RL15 - Sample-and-hold happens two converter cycles after conversion start.
// RL16 - Ready flag clears on result read or on writing one to it.
// RL17 - Sample delay and length each extend sampling; total is two plus both.
// RL18 - Free-running period is thirteen plus sample delay plus sample length.
// RL19 - A resolution select bit chooses a result below ten bits.
// RL20 - Software sets up resolution, mode, count, reference, clock, channel, event, then enable.
// RL21 - The ten-bit result is right-adjusted in the result register.
// RL22 - Channel and reference lock at start and track again in the last cycle.
// RL23 - Up to sixty-four samples accumulate into one result, per the count field.
// RL24 - Accumulated samples are summed; ready flag rises after the last one.
`timescale 1ns/1ps
module adc_conversion_sequencer
	import adc_seq_pkg::*;
(
	input wire logic         clk,
	input wire logic         rst_n,
	input wire logic  [3:0]  address,
	input wire logic         read,
	input wire logic         write,
	input wire logic  [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input wire logic         event_in,
	input wire logic         global_int_enable,
	input wire logic  [9:0]  core_result,
	output logic             irq,
	output logic             sample_hold,
	output logic             converting,
	output logic      [4:0]  channel,
	output logic      [1:0]  reference,
	output logic             resolution_low
);
	// Software registers
	logic [2:0]  ctrl_a_q;
	logic [2:0]  acc_cnt_q;
	logic [2:0]  div_q;
	logic [1:0]  ref_sel_q;
	logic [3:0]  dly_q;
	logic [4:0]  len_q;
	logic [4:0]  mux_q;
	logic        start_conversion_bit_q;
	logic        start_conversion_bit_d;
	logic        stop_q;
	logic        stop_d;
	logic        ev_en_q;
	logic        ie_q;
	logic        flag_q;
	logic        flag_d;
	logic [15:0] res_q;
	// Sequencer state
	state_t      state_q;
	state_t      state_d;
	logic [5:0]  cyc_q;
	logic [5:0]  samp_q;
	logic        ev_q;
	logic        final_q;
	logic        sh_q;
	logic        conv_q;
	logic [4:0]  ch_q;
	logic [1:0]  refl_q;
	logic        irq_q;
	logic        wait_q;
	logic [31:0] rdata_q;
	logic [15:0] acc_sum;

	conv_clk_if clk_bus ();

	adc_prescaler u_clock_divider_select (
		.clk   (clk),
		.rst_n (rst_n),
		.bus   (clk_bus.clock_divider_select)
	);

	// Bus decode: a request is taken on the edge where waitrequest is low
	wire        enable_w = ctrl_a_q[ENABLE_BIT];
	wire        cont_w   = ctrl_a_q[CONT_BIT];
	wire        wr_ok    = write && !wait_q;
	wire        rd_ok    = read && !wait_q;
	wire        we_a     = wr_ok && (address == OFF_CONTROL_A);
	wire        we_b     = wr_ok && (address == OFF_CONTROL_B);
	wire        we_c     = wr_ok && (address == OFF_CONTROL_C);
	wire        we_d     = wr_ok && (address == OFF_CONTROL_D);
	wire        we_s     = wr_ok && (address == OFF_SAMPLE_CTRL);
	wire        we_ch    = wr_ok && (address == OFF_CHANNEL);
	wire        we_cmd   = wr_ok && (address == OFF_COMMAND);
	wire        we_ev    = wr_ok && (address == OFF_EVENT_CTRL);
	wire        we_ie    = wr_ok && (address == OFF_INT_ENABLE);
	wire        we_flag  = wr_ok && (address == OFF_INT_FLAG);
	wire        rd_res   = rd_ok && (address == OFF_RESULT);
	wire [31:0] rd_mux   =
		(address == OFF_CONTROL_A)   ? {29'h0, ctrl_a_q} :
		(address == OFF_CONTROL_B)   ? {29'h0, acc_cnt_q} :
		(address == OFF_CONTROL_C)   ? {26'h0, ref_sel_q, 1'b0, div_q} :
		(address == OFF_CONTROL_D)   ? {28'h0, dly_q} :
		(address == OFF_SAMPLE_CTRL) ? {27'h0, len_q} :
		(address == OFF_CHANNEL)     ? {27'h0, mux_q} :
		(address == OFF_COMMAND)     ? {31'h0, start_conversion_bit_q} : // RL2
		(address == OFF_EVENT_CTRL)  ? {31'h0, ev_en_q} :
		(address == OFF_INT_ENABLE)  ? {31'h0, ie_q} :
		(address == OFF_INT_FLAG)    ? {31'h0, flag_q} :
		(address == OFF_RESULT)      ? {16'h0, res_q} : 32'h0;

	// Conversion timing
	wire [2:0]  acc_eff   = (acc_cnt_q > ACC_MAX_LOG) ? ACC_MAX_LOG : acc_cnt_q;
	wire [6:0]  n_samp    = 7'h01 << acc_eff; // RL23
	wire        last_samp = {1'b0, samp_q} == n_samp - 7'h01;
	wire [5:0]  extra     = {2'h0, dly_q} + {1'h0, len_q};
	wire [5:0]  total     = CONV_CYCLES + extra; // RL14 RL18
	wire [5:0]  sh_point  = SH_CYCLES + extra; // RL15 RL17
	wire        tick      = clk_bus.tick;
	wire        running   = state_q == ST_RUN;
	wire        last_cyc  = running && (cyc_q == total - 6'h01);
	// Count moves only on a tick, so each value spans one full converter clock
	wire [5:0]  cyc_d     = !running ? 6'h00 : !tick ? cyc_q : last_cyc ? 6'h00 : cyc_q + 6'h01; // RL14
	wire        done      = tick && last_cyc;
	wire        final_w   = done && last_samp; // RL24
	wire        ev_rise   = event_in && !ev_q && ev_en_q; // RL7 RL8
	wire        sw_start  = we_cmd && writedata[0]; // RL1
	wire        sw_stop   = we_cmd && !writedata[0] && cont_w;
	// A free-run stop keeps the start bit up until the running burst completes
	wire        stop_req  = sw_stop || stop_q;
	wire        hw_clear  = final_w && (!cont_w || stop_q); // RL2 RL8 RL9
	wire        track     = !running || last_cyc; // RL3 RL22
	wire        sh_d      = running && tick && !last_cyc && (cyc_q == sh_point - 6'h01);
	wire [9:0]  sample_w  = ctrl_a_q[RESLOW_BIT] ? {2'h0, core_result[9:2]} : core_result; // RL19 RL21
	wire        flag_clr  = rd_res || (we_flag && writedata[0]); // RL16

	assign clk_bus.run     = enable_w && (state_q != ST_IDLE); // RL11 RL13
	assign clk_bus.div_sel = div_q;

	// A new trigger wins over the completion clear
	assign start_conversion_bit_d = enable_w && ((sw_start || ev_rise) || (start_conversion_bit_q && !hw_clear)); // RL2
	assign stop_d   = enable_w && stop_req && !(sw_start || ev_rise) && !hw_clear; // RL9
	assign flag_d   = final_q || (flag_q && !flag_clr); // RL4 RL6

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (start_conversion_bit_q) begin
					state_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (tick) begin
					state_d = ST_RUN; // RL12
				end
			end
			ST_RUN: begin
				if (final_w && !(cont_w && start_conversion_bit_d)) begin
					state_d = ST_IDLE; // RL9
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (!enable_w) begin
			state_d = ST_IDLE;
		end
	end

	adc_accumulator u_acc (
		.clk    (clk),
		.rst_n  (rst_n),
		.load   (done && samp_q == 6'h00),
		.add    (done && samp_q != 6'h00),
		.sample (sample_w),
		.sum    (acc_sum)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_a_q  <= CTRL_A_RST;
			acc_cnt_q <= ACC_RST;
			div_q     <= DIV_RST;
			ref_sel_q <= REF_RST;
			dly_q     <= DLY_RST;
			len_q     <= LEN_RST;
			mux_q     <= CH_RST;
			ev_en_q   <= 1'b0;
			ie_q      <= 1'b0;
		end else begin
			if (we_a) ctrl_a_q <= writedata[2:0];
			if (we_b) acc_cnt_q <= writedata[2:0];
			if (we_c) div_q <= writedata[2:0];
			if (we_c) ref_sel_q <= writedata[REF_LSB +: 2];
			if (we_d) dly_q <= writedata[3:0];
			if (we_s) len_q <= writedata[4:0];
			if (we_ch) mux_q <= writedata[4:0];
			if (we_ev) ev_en_q <= writedata[0];
			if (we_ie) ie_q <= writedata[0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0;
		end else begin
			wait_q  <= !((read || write) && wait_q);
			rdata_q <= rd_mux;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= ST_IDLE;
			start_conversion_bit_q <= 1'b0;
			stop_q   <= 1'b0;
			cyc_q    <= 6'h00;
			samp_q   <= 6'h00;
			ev_q     <= 1'b0;
			final_q  <= 1'b0;
			sh_q     <= 1'b0;
			conv_q   <= 1'b0;
		end else begin
			state_q  <= state_d;
			start_conversion_bit_q <= start_conversion_bit_d;
			stop_q   <= stop_d;
			cyc_q    <= cyc_d;
			samp_q   <= (state_d != ST_RUN) ? 6'h00 : done ? (last_samp ? 6'h00 : samp_q + 6'h01) : samp_q;
			ev_q     <= event_in;
			final_q  <= final_w;
			sh_q     <= sh_d; // RL15
			conv_q   <= state_d == ST_RUN;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_q <= 1'b0;
			res_q  <= 16'h0000;
			irq_q  <= 1'b0;
			ch_q   <= CH_RST;
			refl_q <= REF_RST;
		end else begin
			flag_q <= flag_d;
			if (final_q) res_q <= acc_sum; // RL4
			irq_q  <= flag_d && ie_q && global_int_enable; // RL5
			if (track) ch_q <= mux_q;
			if (track) refl_q <= ref_sel_q;
		end
	end

	assign readdata       = rdata_q;
	assign waitrequest    = wait_q;
	assign irq            = irq_q;
	assign sample_hold    = sh_q;
	assign converting     = conv_q;
	assign channel        = ch_q;
	assign reference      = refl_q;
	assign resolution_low = ctrl_a_q[RESLOW_BIT];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_trigger;
		state_q == ST_IDLE && enable_w && start_conversion_bit_q && !we_a;
	endsequence
	sequence s_restart;
		final_w && cont_w && start_conversion_bit_d && enable_w;
	endsequence

	property p_start;
		s_trigger |=> state_q == ST_WAIT;
	endproperty
	a_start: assert property (p_start) else $error("trigger did not start wait"); // RL1
	property p_busy;
		state_q != ST_IDLE && enable_w |-> start_conversion_bit_q;
	endproperty
	a_busy: assert property (p_busy) else $error("start bit low while busy"); // RL2
	property p_single_clear;
		final_w && !cont_w && !sw_start && !ev_rise |=> !start_conversion_bit_q && state_q == ST_IDLE;
	endproperty
	a_single_clear: assert property (p_single_clear) else $error("single mode not cleared"); // RL2
	property p_lock;
		running && !last_cyc && enable_w |=> $stable(ch_q) && $stable(refl_q);
	endproperty
	a_lock: assert property (p_lock) else $error("selection changed mid conversion"); // RL22
	property p_flag;
		final_w |=> ##1 flag_q && res_q == acc_sum;
	endproperty
	a_flag: assert property (p_flag) else $error("ready flag or result missing"); // RL4
	property p_irq;
		irq_q |-> flag_q && $past(ie_q) && $past(global_int_enable);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt without enables"); // RL5
	property p_event;
		ev_rise && enable_w |=> start_conversion_bit_q;
	endproperty
	a_event: assert property (p_event) else $error("event edge lost"); // RL8
	property p_sh;
		sample_hold |-> cyc_q == SH_CYCLES + $past(extra);
	endproperty
	a_sh: assert property (p_sh) else $error("sample-and-hold at wrong cycle"); // RL17
	property p_continuous_conversion_enable;
		s_restart |=> running && cyc_q == 6'h00;
	endproperty
	a_continuous_conversion_enable: assert property (p_continuous_conversion_enable) else $error("free-run did not restart"); // RL9
	property p_flag_clear;
		flag_q && rd_res && !final_q |=> !flag_q;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("read did not clear flag"); // RL16
	property p_irq_set;
		flag_q && !flag_clr && ie_q && global_int_enable |=> irq_q;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("interrupt not requested"); // RL5
	property p_poll;
		final_q |=> flag_q;
	endproperty
	a_poll: assert property (p_poll) else $error("ready flag not set on completion"); // RL6
	property p_res_hold;
		!final_q |=> $stable(res_q);
	endproperty
	a_res_hold: assert property (p_res_hold) else $error("result changed without completion"); // RL4
	property p_disable;
		!enable_w |=> state_q == ST_IDLE && !start_conversion_bit_q;
	endproperty
	a_disable: assert property (p_disable) else $error("sequencer active while disabled"); // RL11
	property p_start_hold;
		state_q == ST_WAIT && !tick && enable_w |=> state_q == ST_WAIT;
	endproperty
	a_start_hold: assert property (p_start_hold) else $error("conversion started off the tick"); // RL12
	property p_stop;
		stop_q && final_w && !sw_start && !ev_rise |=> state_q == ST_IDLE && !start_conversion_bit_q;
	endproperty
	a_stop: assert property (p_stop) else $error("free-run did not stop after burst"); // RL9
endmodule : adc_conversion_sequencer

// ### tb/adc_core_model.sv
`timescale 1ns/1ps
module adc_core_model (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       sample_hold,
	input wire logic [4:0] channel,
	input wire logic       fire,
	output logic     [9:0] core_result,
	output logic           event_in,
	output logic     [7:0] held_count
);
	// Each held sample carries its channel and a running tag so sums stay traceable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			held_count  <= 8'h00;
			core_result <= 10'h000;
			event_in    <= 1'b0;
		end else begin
			event_in <= fire;
			if (sample_hold) begin
				held_count  <= held_count + 8'h01;
				core_result <= {channel, held_count[4:0] + 5'h01};
			end
		end
	end
endmodule : adc_core_model

// ### tb/adc_conversion_sequencer_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module adc_conversion_sequencer_tb;
	import adc_seq_pkg::*;
	logic        clk, rst_n, read, write, global_int_enable, fire;
	logic [3:0]  address;
	logic [31:0] writedata, readdata;
	logic        waitrequest, event_in, irq, sample_hold, converting, resolution_low, conv_d;
	logic [9:0]  core_result;
	logic [4:0]  channel, ch;
	logic [1:0]  reference;
	logic [7:0]  n0, held_count;
	logic [15:0] acc;
	int          fails, n_compared, cyc, t_rise, t_fall, t_sh, t_cmd, sh_gap, dly, len;
	logic [31:0] exp_v;
	string       nm_v;
	logic [31:0] exp_q[$];
	string       name_q[$];

	adc_conversion_sequencer dut_u (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .event_in(event_in),
		.global_int_enable(global_int_enable), .core_result(core_result), .irq(irq), .sample_hold(sample_hold),
		.converting(converting), .channel(channel), .reference(reference), .resolution_low(resolution_low));

	adc_core_model partner_u (.clk(clk), .rst_n(rst_n), .sample_hold(sample_hold), .channel(channel),
		.fire(fire), .core_result(core_result), .event_in(event_in), .held_count(held_count));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Timestamps of conversion edges and held samples, plus the read scoreboard
	always @(posedge clk) begin
		cyc++;
		if (converting === 1'b1 && conv_d !== 1'b1) t_rise = cyc;
		if (converting !== 1'b1 && conv_d === 1'b1) t_fall = cyc;
		if (sample_hold === 1'b1) begin
			sh_gap = cyc - t_sh;
			t_sh   = cyc;
		end
		if (write === 1'b1 && waitrequest === 1'b0 && address === OFF_COMMAND) t_cmd = cyc;
		if (read === 1'b1 && waitrequest === 1'b0) begin
			if (exp_q.size() == 0) begin
				fails++;
				$display("[FAIL] read expected none seen %0h", readdata);
			end else begin
				exp_v = exp_q.pop_front();
				nm_v  = name_q.pop_front();
				`CHK(nm_v, exp_v, readdata)
			end
		end
		conv_d = converting;
	end

	task automatic bus(input logic is_rd, input logic [3:0] a, input logic [31:0] d);
		address   <= a;
		writedata <= d;
		read      <= is_rd;
		write     <= !is_rd;
		@(posedge clk);
		while (waitrequest !== 1'b0) @(posedge clk);
		read  <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
		exp_q.push_back(e);
		name_q.push_back(nm);
		bus(1'b1, a, 32'h0);
	endtask : rd

	task automatic wait_conv(input logic v);
		for (int i = 0; i < 4000 && converting !== v; i++) @(posedge clk);
		`CHK("converting", v, converting)
	endtask : wait_conv

	task automatic wait_sh(input logic [7:0] t);
		for (int i = 0; i < 4000 && held_count !== t; i++) @(posedge clk);
		`CHK("held samples", t, held_count)
	endtask : wait_sh

	// Setup order: resolution and mode, count, clock and reference, timing, channel, event, enable
	task automatic cfg(input logic [2:0] m, input logic [2:0] n, input logic [5:0] c, input logic ev);
		bus(1'b0, OFF_CONTROL_A, {29'h0, m & 3'h6});
		bus(1'b0, OFF_CONTROL_B, {29'h0, n});
		bus(1'b0, OFF_CONTROL_C, {26'h0, c});
		bus(1'b0, OFF_CONTROL_D, dly);
		bus(1'b0, OFF_SAMPLE_CTRL, len);
		bus(1'b0, OFF_CHANNEL, {27'h0, ch});
		bus(1'b0, OFF_EVENT_CTRL, {31'h0, ev});
		bus(1'b0, OFF_CONTROL_A, {29'h0, m});
	endtask : cfg

	task automatic print_verdict;
		$display("compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict

	initial begin
		#100000;
		fails++;
		print_verdict();
	end

	initial begin
		rst_n             = 1'b0;
		read              = 1'b0;
		write             = 1'b0;
		address           = 4'h0;
		writedata         = 32'h0;
		global_int_enable = 1'b0;
		fire              = 1'b0;
		void'($urandom(32'hb504));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		bus(1'b0, 4'hb, 32'hffff_ffff);
		for (int a = 0; a < 16; a++) rd(4'(a), 32'h0, "reset or unmapped");
		bus(1'b0, OFF_CONTROL_C, 32'h21);
		rd(OFF_CONTROL_C, 32'h21, "control c");
		$display("test registers done");

		dly = 0;
		len = 0;
		ch  = 5'($urandom);
		cfg(3'h1, 3'h0, 6'h11, 1'b0);
		n0 = held_count;
		bus(1'b0, OFF_COMMAND, 32'h1);
		wait_conv(1'b1);
		rd(OFF_COMMAND, 32'h1, "busy start bit");
		bus(1'b0, OFF_CHANNEL, {27'h0, ~ch});
		`CHK("locked channel", ch, channel)
		wait_conv(1'b0);
		repeat (4) @(posedge clk);
		`CHK("start delay", 4, t_rise - t_cmd)
		`CHK("conversion length", 52, t_fall - t_rise)
		`CHK("sample point", 8, t_sh - t_rise)
		`CHK("channel after", ~ch, channel)
		`CHK("locked reference", 2'h1, reference)
		rd(OFF_COMMAND, 32'h0, "start bit cleared");
		rd(OFF_INT_FLAG, 32'h1, "ready flag");
		rd(OFF_RESULT, {22'h0, ch, 5'(n0 + 8'h1)}, "result");
		rd(OFF_INT_FLAG, 32'h0, "flag after read");
		`CHK("irq idle", 1'b0, irq)
		$display("test single done");

		ch = ~ch;
		cfg(3'h1, 3'h0, 6'h10, 1'b1);
		bus(1'b0, OFF_INT_ENABLE, 32'h1);
		fire <= 1'b1;
		wait_conv(1'b1);
		rd(OFF_COMMAND, 32'h1, "event start bit");
		wait_conv(1'b0);
		repeat (30) @(posedge clk);
		`CHK("level ignored", 1'b0, converting)
		`CHK("irq masked", 1'b0, irq)
		global_int_enable <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK("irq raised", 1'b1, irq)
		bus(1'b0, OFF_INT_FLAG, 32'h1);
		rd(OFF_INT_FLAG, 32'h0, "flag cleared");
		`CHK("irq cleared", 1'b0, irq)
		fire <= 1'b0;
		bus(1'b0, OFF_EVENT_CTRL, 32'h0);
		fire <= 1'b1;
		repeat (40) @(posedge clk);
		`CHK("event disabled", 1'b0, converting)
		$display("test event done");

		fire <= 1'b0;
		dly = $urandom % 16;
		len = $urandom % 32;
		cfg(3'h7, 3'h2, 6'h10, 1'b0);
		bus(1'b0, OFF_COMMAND, 32'h1);
		wait_conv(1'b1);
		n0  = held_count;
		acc = 16'h0;
		for (int k = 1; k < 5; k++) acc += 16'({ch, 5'(n0 + 8'(k))} >> 2);
		wait_sh(n0 + 8'h1);
		`CHK("sampling time", (2 + dly + len) * 2, t_sh - t_rise)
		`CHK("low resolution", 1'b1, resolution_low)
		wait_sh(n0 + 8'h2);
		`CHK("free-run period", (13 + dly + len) * 2, sh_gap)
		wait_sh(n0 + 8'h4);
		repeat (26) @(posedge clk);
		rd(OFF_INT_FLAG, 32'h1, "burst flag");
		rd(OFF_RESULT, {16'h0, acc}, "accumulated");
		bus(1'b0, OFF_COMMAND, 32'h0);
		wait_conv(1'b0);
		repeat (20) @(posedge clk);
		`CHK("stopped", 1'b0, converting)
		bus(1'b0, OFF_CONTROL_A, 32'h0);
		rd(OFF_COMMAND, 32'h0, "disabled start bit");
		$display("test free-run done");
		print_verdict();
	end
endmodule : adc_conversion_sequencer_tb
